// File: logic/rtcc_pkg.sv
package rtcc_pkg;
    localparam logic [3:0] ADR_SEC = 4'h0;
    localparam logic [3:0] ADR_SEC_ALM = 4'h1;
    localparam logic [3:0] ADR_MIN = 4'h2;
    localparam logic [3:0] ADR_MIN_ALM = 4'h3;
    localparam logic [3:0] ADR_HR = 4'h4;
    localparam logic [3:0] ADR_HR_ALM = 4'h5;
    localparam logic [3:0] ADR_WDAY = 4'h6;
    localparam logic [3:0] ADR_MDAY = 4'h7;
    localparam logic [3:0] ADR_MON = 4'h8;
    localparam logic [3:0] ADR_YEAR = 4'h9;
    localparam logic [3:0] ADR_CTLA = 4'ha;
    localparam logic [3:0] ADR_CTLB = 4'hb;
    localparam logic [3:0] ADR_STAT = 4'hc;
    localparam int N_BYTES = 10;
    // Byte slots that track the counters, and those whose reset value is one
    localparam logic [9:0] COUNT_MASK = 10'h3d5;
    localparam logic [9:0] ONE_MASK = 10'h1c0;
    // Rate and divider control fields
    localparam int CA_UIP = 7;
    localparam logic [2:0] DIV_RUN = 3'h2;
    localparam logic [2:0] DIV_ALT = 3'h3;
    localparam logic [7:0] CTLA_RST = 8'h20;
    // Format and enable control fields
    localparam int CB_UTI = 7;
    localparam int CB_PIE = 6;
    localparam int CB_AIE = 5;
    localparam int CB_UIE = 4;
    localparam int CB_SQWE = 3;
    localparam int CB_DF = 2;
    localparam int CB_HF = 1;
    localparam logic [7:0] CTLB_RST = 8'h02;
    // Status fields
    localparam int CS_IRQF = 7;
    localparam int CS_PF = 6;
    localparam int CS_AF = 5;
    localparam int CS_UF = 4;
    // Divider taps
    localparam int DIV_W = 15;
    localparam logic [3:0] TAP_256HZ = 4'h6;
    localparam logic [3:0] TAP_128HZ = 4'h7;
    localparam logic [3:0] TAP_OFS = 4'h2;
    // Ranges
    localparam logic [7:0] SEC_MAX = 8'h3b;
    localparam logic [7:0] HR_MAX = 8'h17;
    localparam logic [7:0] HR_HALF = 8'h0c;
    localparam logic [7:0] WDAY_MAX = 8'h07;
    localparam logic [7:0] MON_MAX = 8'h0c;
    localparam logic [7:0] YEAR_MAX = 8'h63;
    localparam logic [7:0] TEN = 8'h0a;
    localparam logic [1:0] ALARM_DC = 2'h3;
    typedef enum logic [2:0] {
        UPD_IDLE = 3'b001,
        UPD_ADV = 3'b010,
        UPD_DONE = 3'b100
    } rtcc_upd_t;
endpackage

// File: logic/rtcc_core.sv
`timescale 1ns/1ns
module rtcc_core #(
    parameter int UIP_LEAD = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic osc_tick,
    input wire logic battery_mode,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    output logic square_wave_out,
    output logic irq_n_out,
    output logic irq_n_oe
);
    localparam logic [rtcc_pkg::DIV_W-1:0] DIV_TOP = '1;
    localparam logic [rtcc_pkg::DIV_W-1:0] UIP_START = DIV_TOP - rtcc_pkg::DIV_W'(UIP_LEAD);

    function automatic logic [7:0] to_fmt(input logic [7:0] v, input logic bin);
        logic [7:0] t;
        logic [7:0] u;
        t = v / rtcc_pkg::TEN;
        u = v % rtcc_pkg::TEN;
        return bin ? v : {t[3:0], u[3:0]};
    endfunction

    function automatic logic [7:0] from_fmt(input logic [7:0] v, input logic bin);
        return bin ? v : {4'h0, v[7:4]} * rtcc_pkg::TEN + {4'h0, v[3:0]};
    endfunction

    function automatic logic [7:0] to_hr(input logic [7:0] h, input logic bin, input logic h24);
        logic [7:0] h12;
        logic [7:0] e;
        h12 = h % rtcc_pkg::HR_HALF;
        if (h12 == 8'h00)
            h12 = rtcc_pkg::HR_HALF;
        e = to_fmt(h12, bin);
        return h24 ? to_fmt(h, bin) : {h >= rtcc_pkg::HR_HALF, e[6:0]};
    endfunction

    function automatic logic [7:0] from_hr(input logic [7:0] v, input logic bin, input logic h24);
        logic [7:0] t;
        t = from_fmt({1'b0, v[6:0]}, bin);
        if (t == rtcc_pkg::HR_HALF)
            t = 8'h00;
        return h24 ? from_fmt(v, bin) : t + (v[7] ? rtcc_pkg::HR_HALF : 8'h00);
    endfunction

    function automatic logic [7:0] days_in(input logic [7:0] m, input logic [7:0] y);
        unique case (m)
            8'h02: return (y[1:0] == 2'h0) ? 8'h1d : 8'h1c;
            8'h04, 8'h06, 8'h09, 8'h0b: return 8'h1e;
            default: return 8'h1f;
        endcase
    endfunction

    function automatic logic [3:0] tap_sel(input logic [3:0] rs);
        unique case (rs)
            4'h1: return rtcc_pkg::TAP_256HZ;
            4'h2: return rtcc_pkg::TAP_128HZ;
            default: return rs - rtcc_pkg::TAP_OFS;
        endcase
    endfunction

    logic [7:0] ctla_r;
    logic [7:0] ctlb_r;
    logic uip_r;
    logic [rtcc_pkg::DIV_W-1:0] div_r;
    logic sqw_r;
    logic sqw_out_r;
    logic [7:0] sec_r, min_r, hr_r, wday_r, mday_r, mon_r, year_r;
    logic [7:0] user_r [0:rtcc_pkg::N_BYTES-1];
    logic [7:0] cur_enc [0:rtcc_pkg::N_BYTES-1];
    logic pf_r, af_r, uf_r, irqf_r;
    logic [7:0] rdata_r;
    rtcc_pkg::rtcc_upd_t upd_st;

    logic host_wr;
    logic stat_rd;
    logic bin;
    logic h24;
    logic update_transfer_inhibit;
    logic running;
    logic sec_tick;
    logic tap_now;
    logic pf_ev;
    logic af_ev;
    logic uf_ev;
    logic irq_ev;
    logic c_min, c_hr, c_day, c_mon, c_yr;

    // Backup operation only write-protects the bytes; timekeeping and events carry on
    assign host_wr = wr_en && !battery_mode;
    assign stat_rd = rd_en && addr == rtcc_pkg::ADR_STAT;
    assign bin = ctlb_r[rtcc_pkg::CB_DF];
    assign h24 = ctlb_r[rtcc_pkg::CB_HF];
    assign update_transfer_inhibit = ctlb_r[rtcc_pkg::CB_UTI];

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            ctla_r <= rtcc_pkg::CTLA_RST;
        else if (host_wr && addr == rtcc_pkg::ADR_CTLA)
            ctla_r <= {1'b0, wdata[6:0]};
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            ctlb_r <= rtcc_pkg::CTLB_RST;
        else if (host_wr && addr == rtcc_pkg::ADR_CTLB)
            ctlb_r <= wdata;
    end

    // Both the normal and the alternate code keep the taps running
    assign running = ctla_r[6:4] == rtcc_pkg::DIV_RUN || ctla_r[6:4] == rtcc_pkg::DIV_ALT;
    assign sec_tick = osc_tick && running && div_r == DIV_TOP;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            div_r <= '0;
        else if (!running)
            div_r <= '0;
        else if (osc_tick)
            div_r <= div_r + 1'b1;
    end

    assign tap_now = (ctla_r[3:0] != 4'h0) && div_r[tap_sel(ctla_r[3:0])];
    // One event per tap period, on the falling half
    assign pf_ev = sqw_r && !tap_now;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sqw_r <= 1'b0;
            sqw_out_r <= 1'b0;
        end
        else
        begin
            sqw_r <= tap_now;
            sqw_out_r <= tap_now && ctlb_r[rtcc_pkg::CB_SQWE];
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            upd_st <= rtcc_pkg::UPD_IDLE;
        else
        begin
            unique case (upd_st)
                rtcc_pkg::UPD_IDLE: if (sec_tick) upd_st <= rtcc_pkg::UPD_ADV;
                rtcc_pkg::UPD_ADV: upd_st <= rtcc_pkg::UPD_DONE;
                rtcc_pkg::UPD_DONE: upd_st <= rtcc_pkg::UPD_IDLE;
                default: upd_st <= rtcc_pkg::UPD_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            uip_r <= 1'b0;
        else if (upd_st == rtcc_pkg::UPD_DONE)
            uip_r <= 1'b0;
        else if (osc_tick && running && div_r == UIP_START)
            uip_r <= 1'b1;
    end

    assign c_min = sec_r == rtcc_pkg::SEC_MAX;
    assign c_hr = c_min && min_r == rtcc_pkg::SEC_MAX;
    assign c_day = c_hr && hr_r == rtcc_pkg::HR_MAX;
    assign c_mon = c_day && mday_r == days_in(mon_r, year_r);
    assign c_yr = c_mon && mon_r == rtcc_pkg::MON_MAX;

    // Counters keep binary internally; host writes are decoded in the current format
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sec_r <= 8'h00;
            min_r <= 8'h00;
            hr_r <= 8'h00;
            wday_r <= 8'h01;
            mday_r <= 8'h01;
            mon_r <= 8'h01;
            year_r <= 8'h00;
        end
        else if (host_wr)
        begin
            unique case (addr)
                rtcc_pkg::ADR_SEC: sec_r <= from_fmt(wdata, bin);
                rtcc_pkg::ADR_MIN: min_r <= from_fmt(wdata, bin);
                rtcc_pkg::ADR_HR: hr_r <= from_hr(wdata, bin, h24);
                rtcc_pkg::ADR_WDAY: wday_r <= from_fmt(wdata, bin);
                rtcc_pkg::ADR_MDAY: mday_r <= from_fmt(wdata, bin);
                rtcc_pkg::ADR_MON: mon_r <= from_fmt(wdata, bin);
                rtcc_pkg::ADR_YEAR: year_r <= from_fmt(wdata, bin);
                default: ;
            endcase
        end
        else if (upd_st == rtcc_pkg::UPD_ADV)
        begin
            sec_r <= c_min ? 8'h00 : sec_r + 8'h01;
            if (c_min)
                min_r <= c_hr ? 8'h00 : min_r + 8'h01;
            if (c_hr)
                hr_r <= c_day ? 8'h00 : hr_r + 8'h01;
            if (c_day)
                wday_r <= (wday_r == rtcc_pkg::WDAY_MAX) ? 8'h01 : wday_r + 8'h01;
            if (c_day)
                mday_r <= c_mon ? 8'h01 : mday_r + 8'h01;
            if (c_mon)
                mon_r <= c_yr ? 8'h01 : mon_r + 8'h01;
            if (c_yr)
                year_r <= (year_r == rtcc_pkg::YEAR_MAX) ? 8'h00 : year_r + 8'h01;
        end
    end

    always_comb
    begin
        cur_enc = '{default: 8'h00};
        cur_enc[rtcc_pkg::ADR_SEC] = to_fmt(sec_r, bin);
        cur_enc[rtcc_pkg::ADR_MIN] = to_fmt(min_r, bin);
        cur_enc[rtcc_pkg::ADR_HR] = to_hr(hr_r, bin, h24);
        cur_enc[rtcc_pkg::ADR_WDAY] = to_fmt(wday_r, bin);
        cur_enc[rtcc_pkg::ADR_MDAY] = to_fmt(mday_r, bin);
        cur_enc[rtcc_pkg::ADR_MON] = to_fmt(mon_r, bin);
        cur_enc[rtcc_pkg::ADR_YEAR] = to_fmt(year_r, bin);
    end

    // Host copy: alarm slots hold what was written, count slots follow the counters
    for (genvar a = 0; a < rtcc_pkg::N_BYTES; a++)
    begin : g_user
        always_ff @(posedge sys_clk or posedge rst)
        begin
            if (rst)
                user_r[a] <= rtcc_pkg::ONE_MASK[a] ? 8'h01 : 8'h00;
            else if (host_wr && addr == 4'(a))
                user_r[a] <= wdata;
            else if (rtcc_pkg::COUNT_MASK[a] && upd_st == rtcc_pkg::UPD_DONE && !update_transfer_inhibit)
                user_r[a] <= cur_enc[a];
        end
    end

    assign af_ev = upd_st == rtcc_pkg::UPD_DONE &&
        (user_r[rtcc_pkg::ADR_SEC_ALM][7:6] == rtcc_pkg::ALARM_DC ||
         user_r[rtcc_pkg::ADR_SEC_ALM] == cur_enc[rtcc_pkg::ADR_SEC]) &&
        (user_r[rtcc_pkg::ADR_MIN_ALM][7:6] == rtcc_pkg::ALARM_DC ||
         user_r[rtcc_pkg::ADR_MIN_ALM] == cur_enc[rtcc_pkg::ADR_MIN]) &&
        (user_r[rtcc_pkg::ADR_HR_ALM][7:6] == rtcc_pkg::ALARM_DC ||
         user_r[rtcc_pkg::ADR_HR_ALM] == cur_enc[rtcc_pkg::ADR_HR]);
    assign uf_ev = upd_st == rtcc_pkg::UPD_DONE;
    assign irq_ev = (pf_ev && ctlb_r[rtcc_pkg::CB_PIE]) ||
        (af_ev && ctlb_r[rtcc_pkg::CB_AIE]) ||
        (uf_ev && ctlb_r[rtcc_pkg::CB_UIE] && !update_transfer_inhibit);

    // A new event in the cycle of a status read survives the clear
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pf_r <= 1'b0;
            af_r <= 1'b0;
            uf_r <= 1'b0;
            irqf_r <= 1'b0;
        end
        else
        begin
            pf_r <= pf_ev || (pf_r && !stat_rd);
            af_r <= af_ev || (af_r && !stat_rd);
            uf_r <= uf_ev || (uf_r && !stat_rd);
            irqf_r <= irq_ev || (irqf_r && !stat_rd);
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            rdata_r <= 8'h00;
        else if (rd_en)
        begin
            if (addr < 4'(rtcc_pkg::N_BYTES))
                rdata_r <= user_r[addr];
            else if (addr == rtcc_pkg::ADR_CTLA)
                rdata_r <= {uip_r, ctla_r[6:0]};
            else if (addr == rtcc_pkg::ADR_CTLB)
                rdata_r <= ctlb_r;
            else if (addr == rtcc_pkg::ADR_STAT)
                rdata_r <= {irqf_r, pf_r, af_r, uf_r, 4'h0};
            else
                rdata_r <= 8'h00;
        end
        else
            rdata_r <= 8'h00;
    end

    assign rdata = rdata_r;
    assign square_wave_out = sqw_out_r;
    assign irq_n_out = 1'b0;
    assign irq_n_oe = irqf_r;

    a_stat_clear: assert property (@(posedge sys_clk) disable iff (rst)
        stat_rd && !irq_ev && !pf_ev |=> !irqf_r && !pf_r && !irq_n_oe)
        else $error("status read did not clear flags");

    a_irq_pin: assert property (@(posedge sys_clk) disable iff (rst)
        irq_ev |=> irqf_r && irq_n_oe && !irq_n_out)
        else $error("request not shown on pin");

    a_uti_freeze: assert property (@(posedge sys_clk) disable iff (rst)
        update_transfer_inhibit && !(wr_en && addr == rtcc_pkg::ADR_SEC) |=> $stable(user_r[rtcc_pkg::ADR_SEC]))
        else $error("host copy changed under inhibit");

    a_upd_seq: assert property (@(posedge sys_clk) disable iff (rst)
        sec_tick && upd_st == rtcc_pkg::UPD_IDLE |=> upd_st == rtcc_pkg::UPD_ADV ##1 upd_st == rtcc_pkg::UPD_DONE)
        else $error("update cycle did not follow tick");

    a_uip_end: assert property (@(posedge sys_clk) disable iff (rst)
        upd_st == rtcc_pkg::UPD_DONE |=> !uip_r && uf_r)
        else $error("busy bit or update flag wrong at end");

    a_alarm_dc: assert property (@(posedge sys_clk) disable iff (rst)
        upd_st == rtcc_pkg::UPD_DONE && user_r[rtcc_pkg::ADR_SEC_ALM][7:6] == rtcc_pkg::ALARM_DC &&
        user_r[rtcc_pkg::ADR_MIN_ALM][7:6] == rtcc_pkg::ALARM_DC &&
        user_r[rtcc_pkg::ADR_HR_ALM][7:6] == rtcc_pkg::ALARM_DC |=> af_r)
        else $error("masked alarm did not match");

    a_uf_gated: assert property (@(posedge sys_clk) disable iff (rst)
        uf_ev && update_transfer_inhibit && !(af_ev && ctlb_r[rtcc_pkg::CB_AIE]) && !(pf_ev && ctlb_r[rtcc_pkg::CB_PIE]) &&
        !irqf_r |=> !irqf_r)
        else $error("update request raised under inhibit");

    a_sec_range: assert property (@(posedge sys_clk) disable iff (rst)
        sec_r <= rtcc_pkg::SEC_MAX && hr_r <= rtcc_pkg::HR_MAX)
        else $error("time counter out of range");

    a_sqw_none: assert property (@(posedge sys_clk) disable iff (rst)
        ctla_r[3:0] == 4'h0 |=> !sqw_r && !pf_ev)
        else $error("rate code zero produced output");

    a_periodic: assert property (@(posedge sys_clk) disable iff (rst)
        pf_ev && ctlb_r[rtcc_pkg::CB_PIE] |=> irqf_r && pf_r)
        else $error("periodic request missing");

    c_alarm: cover property (@(posedge sys_clk) disable iff (rst) af_ev && ctlb_r[rtcc_pkg::CB_AIE]);
    c_periodic: cover property (@(posedge sys_clk) disable iff (rst) pf_ev ##1 stat_rd);
    c_update_irq: cover property (@(posedge sys_clk) disable iff (rst) uf_ev && irq_ev);
endmodule // rtcc_core

// File: verif/rtcc_host.sv
`timescale 1ns/1ns
module rtcc_host (
    input wire logic sys_clk,
    output logic [3:0] addr,
    output logic [7:0] wdata,
    output logic wr_en,
    output logic rd_en,
    input wire logic [7:0] rdata
);
    initial
    begin
        addr = 4'h0;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end

    // The slave never stalls, so a strobe lasts exactly one edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
        wdata <= ~d;
    endtask

    // Read data stands only in the cycle after the strobe edge
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask
endmodule // rtcc_host

// File: verif/rtcc_core_tb.sv
`timescale 1ns/1ns
module rtcc_core_tb;
    logic sys_clk;
    logic rst;
    logic osc_tick;
    logic battery_mode;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr_en;
    logic rd_en;
    logic [7:0] rdata;
    logic square_wave_out;
    logic irq_n_out;
    logic irq_n_oe;
    logic irq_line;
    int n_fail = 0;
    int tests_run = 0;

    // Open-drain request line with its pull-up
    assign irq_line = irq_n_oe ? irq_n_out : 1'b1;

    rtcc_core #(.UIP_LEAD(8)) DUT (.sys_clk(sys_clk), .rst(rst), .osc_tick(osc_tick),
        .battery_mode(battery_mode), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .square_wave_out(square_wave_out), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

    rtcc_host host (.sys_clk(sys_clk), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata));

    always #10 sys_clk = ~sys_clk;

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic timeout;
        n_fail++;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
        wrap_up();
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, e);
    endtask

    task automatic wait_sq(input logic lvl);
        int i;
        for (i = 0; i < 1000 && square_wave_out !== lvl; i++)
        begin
            @(posedge sys_clk);
            #1;
        end
        if (i == 1000)
            timeout();
    endtask

    task automatic sq_period(output int p);
        time t0;
        // Skip the edge where the new rate lands, so the first rise counted is a real one
        @(posedge sys_clk);
        #1;
        wait_sq(1'b0);
        wait_sq(1'b1);
        t0 = $time;
        wait_sq(1'b0);
        wait_sq(1'b1);
        p = int'(($time - t0) / 20);
    endtask

    task automatic t_reset;
        rchk(4'ha, 8'h20);
        rchk(4'hb, 8'h02);
        rchk(4'h0, 8'h00);
        rchk(4'h6, 8'h01);
        rchk(4'h8, 8'h01);
        rchk(4'hc, 8'h00);
        rchk(4'hd, 8'h00);
        $display("reset values done");
    endtask

    task automatic t_square;
        int p;
        int highs;
        host.wr(4'hb, 8'h0a);
        for (int c = 1; c <= 8; c++)
        begin
            host.wr(4'ha, {4'h2, c[3:0]});
            sq_period(p);
            chk(p[15:0], (c == 1) ? 16'd128 : (c == 2) ? 16'd256 : 16'd1 << (c - 1));
        end
        host.wr(4'ha, 8'h33);
        sq_period(p);
        chk(p[15:0], 16'd4);
        host.wr(4'ha, 8'h20);
        highs = 0;
        repeat (300)
        begin
            @(posedge sys_clk);
            #1;
            highs += int'(square_wave_out === 1'b1);
        end
        chk(highs[15:0], 16'd0);
        $display("square wave done");
    endtask

    task automatic t_periodic;
        logic [7:0] d;
        int i;
        host.wr(4'ha, 8'h23);
        host.wr(4'hb, 8'h4a);
        host.rd(4'hc, d);
        for (i = 0; i < 20 && irq_n_oe !== 1'b1; i++)
        begin
            @(posedge sys_clk);
            #1;
        end
        if (i == 20)
            timeout();
        chk(irq_line, 1'b0);
        rchk(4'hc, 8'hc0);
        host.wr(4'hb, 8'h0a);
        host.rd(4'hc, d);
        repeat (20) @(posedge sys_clk);
        chk(irq_n_oe, 1'b0);
        rchk(4'hc, 8'h40);
        $display("periodic done");
    endtask

    task automatic t_update_binary;
        // 11:59:59 pm on the last day of a non-leap February rolls into March
        logic [7:0] v[10] = '{8'h3b, 8'h00, 8'h3b, 8'h00, 8'h8b, 8'h0c, 8'h07, 8'h1c, 8'h02, 8'h01};
        logic [7:0] e[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0c, 8'h0c, 8'h01, 8'h01, 8'h03, 8'h01};
        logic [7:0] d;
        int i;
        host.wr(4'ha, 8'h00);
        host.wr(4'hb, 8'h84);
        for (int k = 0; k < 10; k++)
            host.wr(k[3:0], v[k]);
        host.wr(4'hb, 8'h24);
        host.rd(4'hc, d);
        host.wr(4'ha, 8'h20);
        for (i = 0; i < 40000 && irq_n_oe !== 1'b1; i++)
        begin
            @(posedge sys_clk);
            #1;
        end
        if (i == 40000)
            timeout();
        // Full divider length of ticks, then the advance and done cycles
        chk(i[15:0], 16'd32770);
        chk(irq_line, 1'b0);
        rchk(4'hc, 8'hb0);
        chk(irq_n_oe, 1'b0);
        for (int k = 0; k < 10; k++)
            rchk(k[3:0], e[k]);
        $display("binary update done");
    endtask

    task automatic t_update_inhibit;
        logic [7:0] d;
        int i;
        // BCD and 24-hour: the alarm only matches if the time is encoded that way
        host.wr(4'hb, 8'h92);
        host.wr(4'h0, 8'h19);
        host.wr(4'h1, 8'h20);
        host.wr(4'h3, 8'hc0);
        host.wr(4'h5, 8'h00);
        host.rd(4'hc, d);
        battery_mode <= 1'b1;
        host.wr(4'h0, 8'h11);
        d = 8'h00;
        for (i = 0; i < 17000 && d[7] !== 1'b1; i++)
            host.rd(4'ha, d);
        if (i == 17000)
            timeout();
        for (i = 0; i < 20 && d[7] !== 1'b0; i++)
            host.rd(4'ha, d);
        if (i == 20)
            timeout();
        chk(d[7], 1'b0);
        rchk(4'hc, 8'h30);
        chk(irq_n_oe, 1'b0);
        rchk(4'h0, 8'h19);
        battery_mode <= 1'b0;
        $display("inhibit update done");
    endtask

    initial
    begin
        sys_clk = 1'b0;
        rst = 1'b1;
        osc_tick = 1'b1;
        battery_mode = 1'b0;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_square();
        t_periodic();
        t_update_binary();
        t_update_inhibit();
        wrap_up();
    end
endmodule // rtcc_core_tb
